/* rtl/bpc_port.v */
// Functional notes
// - Six or eight pins, one direction bit each
// - Direction one: input, driver high impedance
// - Direction zero: drive pin from latch, or from peripheral when its source bit is set
// - Port read gives pins, write hits latch
// - Port write loads latch directly from write data
// - Latch keeps most recent port/latch write
// - Direction still controls drivers in analog
// - Analog pins read zero digitally
// - Threshold picks Schmitt or TTL input
// - Open-drain bit: sink only, else push-pull
// - I2C owner forces open-drain itself
// - Slew bit limits driver slew rate
// - Analog select forces digital reads zero
// - Analog select leaves digital outputs alone
// - Analog select resets to analog mode
// - Per-pin weak pull-up enable bit
// - Outputs default to latch after reset
// - Pull-up off on outputs unless open-drain
// - Pull-up bit one enables, zero disables
`timescale 1ns/1ps
`default_nettype none
`include "bpc_regs.vh"
module bpc_port #(
   parameter WIDTH = 8
) (
   input wire mclk_i,
   input wire resetn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`BPC_ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire [WIDTH-1:0] pin_schmitt_i,
   input wire [WIDTH-1:0] pin_ttl_i,
   input wire [WIDTH-1:0] periph_out_i,
   input wire [WIDTH-1:0] periph_oe_n_i,
   input wire [WIDTH-1:0] i2c_own_i,
   output reg [WIDTH-1:0] pin_out_o,
   output reg [WIDTH-1:0] pin_oe_n_o,
   output reg [WIDTH-1:0] pin_slew_limit_o,
   output reg [WIDTH-1:0] pin_pullup_o,
   output reg [WIDTH-1:0] pin_analog_o,
   output reg [WIDTH-1:0] pin_digital_in_o
);

   // ----------------------------------------
   // Configuration state
   // ----------------------------------------
   reg [WIDTH-1:0] pin_direction_bits;
   reg [WIDTH-1:0] output_latch;
   reg [WIDTH-1:0] analog_select;
   reg [WIDTH-1:0] pullup_enable;
   reg [WIDTH-1:0] open_drain_enable;
   reg [WIDTH-1:0] slew_limit_enable;
   reg [WIDTH-1:0] input_threshold_select;
   reg [WIDTH-1:0] peripheral_pin_select;
   reg [WIDTH-1:0] next_pin_value;
   reg [WIDTH-1:0] next_drive;
   reg [WIDTH-1:0] next_oe_n;
   reg [WIDTH-1:0] next_pullup;
   reg [31:0] next_rdata;
   reg next_err;
   wire setup;
   wire wr_en;
   wire lane_ok;

   assign setup = psel_i & ~penable_i;
   assign wr_en = psel_i & penable_i & pwrite_i & ~pslverr_o;
   assign lane_ok = pstrb_i[0];

   // ----------------------------------------
   // Register address decode
   // ----------------------------------------
   // One select per register, shared by all write processes
   wire sel_port;
   wire sel_dir;
   wire sel_lat;
   wire sel_ansel;
   wire sel_pullup;
   wire sel_odrain;
   wire sel_slew;
   wire sel_thresh;
   wire sel_src;
   wire wr_take;

   // Full address compare, so no register answers at an alias
   assign sel_port = (paddr_i == `BPC_PORT_ADDR);
   assign sel_dir = (paddr_i == `BPC_DIR_ADDR);
   assign sel_lat = (paddr_i == `BPC_LAT_ADDR);
   assign sel_ansel = (paddr_i == `BPC_ANSEL_ADDR);
   assign sel_pullup = (paddr_i == `BPC_PULLUP_ADDR);
   assign sel_odrain = (paddr_i == `BPC_ODRAIN_ADDR);
   assign sel_slew = (paddr_i == `BPC_SLEW_ADDR);
   assign sel_thresh = (paddr_i == `BPC_THRESH_ADDR);
   assign sel_src = (paddr_i == `BPC_SRC_ADDR);
   // Write lands at the access edge with ready high and lane 0 set
   assign wr_take = wr_en & pready_o & lane_ok;

   // ----------------------------------------
   // Per-pin input, driver and pull-up logic
   // ----------------------------------------
   // Open-drain high releases the pad, so the far side or the pull-up
   // sets the level; the pull-up follows the drive so a low is not fought.
   // Analog select masks only the input path; drivers keep working.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
         // Threshold select and analog masking of the input
         always @* begin
            if (analog_select[g]) begin
               next_pin_value[g] = 1'b0;
            end else if (input_threshold_select[g]) begin
               next_pin_value[g] = pin_schmitt_i[g];
            end else begin
               next_pin_value[g] = pin_ttl_i[g];
            end
         end
         // Driver value, enable and pull-up; analog ignored here
         always @* begin
            if (peripheral_pin_select[g]) begin
               next_drive[g] = periph_out_i[g];
            end else begin
               next_drive[g] = output_latch[g];
            end
            if (pin_direction_bits[g]) begin
               next_oe_n[g] = 1'b1;
            end else if (peripheral_pin_select[g] & periph_oe_n_i[g]) begin
               next_oe_n[g] = 1'b1;
            end else if ((open_drain_enable[g] | i2c_own_i[g])
                         & next_drive[g]) begin
               next_oe_n[g] = 1'b1;
            end else begin
               next_oe_n[g] = 1'b0;
            end
            if (!pullup_enable[g]) begin
               next_pullup[g] = 1'b0;
            end else if (next_oe_n[g] & pin_direction_bits[g]) begin
               next_pullup[g] = 1'b1;
            end else if (open_drain_enable[g] | i2c_own_i[g]) begin
               next_pullup[g] = next_drive[g];
            end else begin
               next_pullup[g] = 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read data mux and address check
   // ----------------------------------------
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr_i == `BPC_PORT_ADDR) begin
         next_rdata[WIDTH-1:0] = next_pin_value;
      end else if (paddr_i == `BPC_DIR_ADDR) begin
         next_rdata[WIDTH-1:0] = pin_direction_bits;
      end else if (paddr_i == `BPC_LAT_ADDR) begin
         next_rdata[WIDTH-1:0] = output_latch;
      end else if (paddr_i == `BPC_ANSEL_ADDR) begin
         next_rdata[WIDTH-1:0] = analog_select;
      end else if (paddr_i == `BPC_PULLUP_ADDR) begin
         next_rdata[WIDTH-1:0] = pullup_enable;
      end else if (paddr_i == `BPC_ODRAIN_ADDR) begin
         next_rdata[WIDTH-1:0] = open_drain_enable;
      end else if (paddr_i == `BPC_SLEW_ADDR) begin
         next_rdata[WIDTH-1:0] = slew_limit_enable;
      end else if (paddr_i == `BPC_THRESH_ADDR) begin
         next_rdata[WIDTH-1:0] = input_threshold_select;
      end else if (paddr_i == `BPC_SRC_ADDR) begin
         next_rdata[WIDTH-1:0] = peripheral_pin_select;
      end else begin
         next_err = 1'b1;
      end
   end

   // ----------------------------------------
   // APB handshake: no wait states, ready in first access cycle
   // ----------------------------------------
   // Read data is captured at setup so it stands through the access cycle
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= setup;
         if (setup) begin
            pslverr_o <= next_err;
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
         end else begin
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // Register writes, taken in the access phase
   // ----------------------------------------
   // Output latch: port and latch writes both land here
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         output_latch <= {WIDTH{`BPC_LAT_RST}};
      end else if (wr_take & (sel_port | sel_lat)) begin
         // Whole-port write lands in the latch
         output_latch <= pwdata_i[WIDTH-1:0];
      end
   end

   // Direction bits, one per pin
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_direction_bits <= {WIDTH{`BPC_DIR_RST}};
      end else if (wr_take & sel_dir) begin
         pin_direction_bits <= pwdata_i[WIDTH-1:0];
      end
   end

   // Analog select, comes up in analog mode
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         analog_select <= {WIDTH{`BPC_ANSEL_RST}};
      end else if (wr_take & sel_ansel) begin
         analog_select <= pwdata_i[WIDTH-1:0];
      end
   end

   // Weak pull-up enables
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pullup_enable <= {WIDTH{`BPC_PULLUP_RST}};
      end else if (wr_take & sel_pullup) begin
         pullup_enable <= pwdata_i[WIDTH-1:0];
      end
   end

   // Open-drain enables
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         open_drain_enable <= {WIDTH{`BPC_ODRAIN_RST}};
      end else if (wr_take & sel_odrain) begin
         open_drain_enable <= pwdata_i[WIDTH-1:0];
      end
   end

   // Slew limit enables
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         slew_limit_enable <= {WIDTH{`BPC_SLEW_RST}};
      end else if (wr_take & sel_slew) begin
         slew_limit_enable <= pwdata_i[WIDTH-1:0];
      end
   end

   // Input threshold selects
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         input_threshold_select <= {WIDTH{`BPC_THRESH_RST}};
      end else if (wr_take & sel_thresh) begin
         input_threshold_select <= pwdata_i[WIDTH-1:0];
      end
   end

   // Pin source: latch or peripheral
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         peripheral_pin_select <= {WIDTH{`BPC_SRC_RST}};
      end else if (wr_take & sel_src) begin
         peripheral_pin_select <= pwdata_i[WIDTH-1:0];
      end
   end

   // ----------------------------------------
   // Registered pin-side outputs
   // ----------------------------------------
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_out_o <= {WIDTH{`BPC_LAT_RST}};
         pin_oe_n_o <= {WIDTH{1'b1}};
         pin_slew_limit_o <= {WIDTH{`BPC_SLEW_RST}};
         pin_pullup_o <= {WIDTH{1'b0}};
         pin_analog_o <= {WIDTH{`BPC_ANSEL_RST}};
         pin_digital_in_o <= {WIDTH{1'b0}};
      end else begin
         pin_out_o <= next_drive;
         pin_oe_n_o <= next_oe_n;
         pin_slew_limit_o <= slew_limit_enable;
         pin_pullup_o <= next_pullup;
         pin_analog_o <= analog_select;
         pin_digital_in_o <= next_pin_value;
      end
   end

endmodule
`default_nettype wire

/* rtl/bpc_regs.vh */
`ifndef BPC_REGS_VH
`define BPC_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BPC_PORT_ADDR 12'h000
`define BPC_DIR_ADDR 12'h004
`define BPC_LAT_ADDR 12'h008
`define BPC_ANSEL_ADDR 12'h00C
`define BPC_PULLUP_ADDR 12'h010
`define BPC_ODRAIN_ADDR 12'h014
`define BPC_SLEW_ADDR 12'h018
`define BPC_THRESH_ADDR 12'h01C
`define BPC_SRC_ADDR 12'h020
`define BPC_ADDR_W 12
// ----------------------------------------
// Reset values (per pin, replicated)
// ----------------------------------------
`define BPC_DIR_RST 1'b1
`define BPC_LAT_RST 1'b0
`define BPC_ANSEL_RST 1'b1
`define BPC_PULLUP_RST 1'b0
`define BPC_ODRAIN_RST 1'b0
`define BPC_SLEW_RST 1'b1
`define BPC_THRESH_RST 1'b1
`define BPC_SRC_RST 1'b0
`endif

/* bench/bpc_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module bpc_port_asserts #(
   parameter WIDTH = 8
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [WIDTH-1:0] pin_schmitt_i,
   input wire logic [WIDTH-1:0] pin_ttl_i,
   input wire logic [WIDTH-1:0] i2c_own_i,
   input wire logic [WIDTH-1:0] pin_out_o,
   input wire logic [WIDTH-1:0] pin_oe_n_o,
   input wire logic [WIDTH-1:0] pin_pullup_o,
   input wire logic [WIDTH-1:0] pin_analog_o,
   input wire logic [WIDTH-1:0] pin_digital_in_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_one; pready_o |=> !pready_o; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_idle; !pready_o |-> prdata_o == 0 && !pslverr_o; endproperty
   a_idle: assert property (p_idle) else $error("stray data");
   property p_upper; pready_o |-> prdata_o[31:WIDTH] == 0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits");
   property p_amask; (pin_digital_in_o & pin_analog_o) == 0; endproperty
   a_amask: assert property (p_amask) else $error("analog read");
   property p_thr; ((pin_digital_in_o ^ $past(pin_schmitt_i)) &
      (pin_digital_in_o ^ $past(pin_ttl_i)) & ~pin_analog_o) == 0; endproperty
   a_thr: assert property (p_thr) else $error("bad input");
   property p_pull; (pin_pullup_o & ~pin_oe_n_o) == 0; endproperty
   a_pull: assert property (p_pull) else $error("pull on out");
   property p_i2c; (~pin_oe_n_o & pin_out_o & $past(i2c_own_i)) == 0;
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c drives high");
   c_acc: cover property (psel_i && penable_i && pready_o);
   c_err: cover property (pslverr_o);
   c_pull: cover property (pin_pullup_o != 0);
endmodule
bind bpc_port bpc_port_asserts #(.WIDTH(WIDTH)) i_bpc_port_asserts (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
   .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .pin_schmitt_i(pin_schmitt_i),
   .pin_ttl_i(pin_ttl_i), .i2c_own_i(i2c_own_i), .pin_out_o(pin_out_o),
   .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o),
   .pin_analog_o(pin_analog_o), .pin_digital_in_o(pin_digital_in_o));
`default_nettype wire

/* bench/bpc_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module bpc_pins (
   input wire logic clk_i,
   input wire logic [7:0] out_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] pull_i,
   input wire logic [7:0] drv_i,
   input wire logic [7:0] drv_en_i,
   input wire logic [7:0] flip_i,
   output logic [7:0] schmitt_o,
   output logic [7:0] ttl_o
);
   logic [7:0] last = 8'h00;
   logic [7:0] free;
   // Released pad: far drive, else pull-up, else a floating toggle
   assign free = (drv_en_i & drv_i)
      | (~drv_en_i & (pull_i | ~last));
   assign schmitt_o = (~oe_n_i & out_i) | (oe_n_i & free);
   assign ttl_o = schmitt_o ^ flip_i;
   always @(posedge clk_i) last <= schmitt_o;
endmodule
`default_nettype wire

/* bench/bpc_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bpc_port_tb;
   logic mclk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic [7:0] drv = 8'h00, drv_en = 8'hff, flip = 8'h00, pout = 8'h00;
   logic [7:0] own = 8'h00, v, l, schm, ttl, out, oe_n, slew, pull, ana, din;
   logic [32:0] q[$];
   int fails = 0, check_count = 0, seed = 99047;
   logic [11:0] ra [8] = '{12'h004, 12'h00c, 12'h010, 12'h014,
      12'h018, 12'h01c, 12'h020, 12'h008};
   logic [7:0] rv [8] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 0, 0};
   always #5 mclk_i = ~mclk_i;
   bpc_port #(.WIDTH(8)) i_bpc_port (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pin_schmitt_i(schm), .pin_ttl_i(ttl),
      .periph_out_i(pout), .periph_oe_n_i(8'h00), .i2c_own_i(own),
      .pin_out_o(out), .pin_oe_n_o(oe_n), .pin_slew_limit_o(slew),
      .pin_pullup_o(pull), .pin_analog_o(ana), .pin_digital_in_o(din));
   bpc_pins i_bpc_pins (.clk_i(mclk_i), .out_i(out), .oe_n_i(oe_n),
      .pull_i(pull), .drv_i(drv), .drv_en_i(drv_en), .flip_i(flip),
      .schmitt_o(schm), .ttl_o(ttl));
   task conclude;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB transfer, held until ready is seen at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (n >= 9) begin
         fails++;
         conclude;
      end else begin
         {psel, penable} <= 2'b00;
      end
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // Read answers are matched against the oldest note
   always @(posedge mclk_i)
      if (pready === 1'b1 && !pwrite && q.size() > 0)
         chk({pslverr, prdata}, q.pop_front());
   initial begin
      repeat (8) @(posedge mclk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 8; i++) rd(ra[i], {25'h0, rv[i]});
      rd(12'h024, 33'h1_0000_0000);
      chk({9'h0, oe_n, ana, slew}, 33'hff_ffff);
      v = 8'($random(seed));
      drv <= v;
      rd(12'h000, 33'h0);
      apb(1'b1, 12'h00c, 32'h0000_0000);
      rd(12'h000, {25'h0, v});
      chk({25'h0, din}, {25'h0, v});
      flip <= 8'h0f;
      apb(1'b1, 12'h01c, 32'h0000_0000);
      rd(12'h000, {25'h0, v ^ 8'h0f});
      flip <= 8'h00;
      l = 8'($random(seed));
      apb(1'b1, 12'h000, {24'h0, l});
      rd(12'h008, {25'h0, l});
      apb(1'b1, 12'h00c, 32'h0000_00ff);
      apb(1'b1, 12'h004, 32'h0000_0000);
      repeat (3) @(posedge mclk_i);
      chk({17'h0, out, oe_n}, {17'h0, l, 8'h00});
      rd(12'h000, 33'h0);
      apb(1'b1, 12'h00c, 32'h0000_0000);
      rd(12'h000, {25'h0, l});
      drv_en <= 8'h00;
      apb(1'b1, 12'h010, 32'h0000_00ff);
      apb(1'b1, 12'h014, 32'h0000_00ff);
      repeat (3) @(posedge mclk_i);
      chk({17'h0, oe_n, pull}, {17'h0, l, l});
      rd(12'h000, {25'h0, l});
      v = 8'($random(seed));
      own <= v;
      apb(1'b1, 12'h014, 32'h0000_0000);
      repeat (3) @(posedge mclk_i);
      chk({17'h0, oe_n, pull}, {17'h0, l & v, l & v});
      own <= 8'h00;
      v = 8'($random(seed));
      pout <= v;
      apb(1'b1, 12'h018, 32'h0000_0000);
      apb(1'b1, 12'h020, 32'h0000_00ff);
      repeat (3) @(posedge mclk_i);
      chk({17'h0, slew, out}, {17'h0, 8'h00, v});
      conclude;
   end
endmodule
`default_nettype wire
